// ### hdl/pot_defines.svh
`ifndef POT_DEFINES_SVH
`define POT_DEFINES_SVH

// ----------------------------------------
// command byte layout
// ----------------------------------------
`define OP_MSB 7
`define OP_LSB 4
`define PAD_MSB 3
`define PAD_LSB 2
`define TGT_A_BIT 0
`define TGT_B_BIT 1

// ----------------------------------------
// operation codes (upper nibble)
// ----------------------------------------
`define OP_WR_WIPER 4'h0
`define OP_WR_NV 4'h1
`define OP_CP_W2NV 4'h2
`define OP_CP_NV2W 4'h3
`define OP_RD_WIPER 4'h4
`define OP_RD_NV 4'h5

// ----------------------------------------
// frame lengths in serial bits
// ----------------------------------------
`define FRAME_SHORT 5'h08
`define FRAME_LONG 5'h10
`define FRAME_SAT 5'h1f

// ----------------------------------------
// reset values
// ----------------------------------------
`define NV_RESET 8'h80
`define WIPER_RESET 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define NV_BUSY_MS 20
`define CLK_KHZ 100000
`define NV_BUSY_CYCLES (`NV_BUSY_MS * `CLK_KHZ)

`endif

// ### hdl/pot_pkg.sv
package pot_pkg;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } exec_state_t;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] data;
    logic [4:0] nbits;
  } frame_t;

endpackage

// ### hdl/dual_wiper_serial_command_unit.sv
`timescale 1ns/1ns
`default_nettype none
`include "pot_defines.svh"

// Operation
// - wiper write: command byte, then data, MSB first
// - zero is low end, all ones high end
// - per-wiper writes and a combined write
// - power-up loads wipers from nonvolatile copies
// - nonvolatile write leaves wipers untouched
// - per-copy and combined nonvolatile writes
// - ready held low during storage cycle
// - copy wiper to nonvolatile, 8 or 16 bits
// - no automatic store at power-down
// - copy nonvolatile to wiper, 8 or 16 bits
// - data pin is input while select low
// - after select rises, drive stored byte out
// - read data starts second clock after rise
// - select falling releases the data pin
// - wiper read shows register, wiper unchanged
// - mute holds both wipers at zero
// - mute discards wiper writes and copies to wipers
// - mute leaves nonvolatile copies alone
// - bits taken on clock rise, run on select rise
// - only 8 or 16 bit frames execute
// - low bits pick target, nibble picks operation
// - storage cycle lasts at most 20 ms
module dual_wiper_serial_command_unit
  import pot_pkg::*;
#(
  parameter int BUSY_CYCLES = `NV_BUSY_CYCLES
) (
  input wire logic mclk, // system clock, 100 MHz
  input wire logic sys_rst, // async reset, active high
  input wire logic sclk, // serial clock from host
  input wire logic chip_select_low, // frame select, active low
  input wire logic sdio_in, // data pin, input level
  output logic sdio_out, // data pin, driven level
  output logic sdio_oe, // data pin, drive enable
  input wire logic mute, // force wipers to zero
  output logic [7:0] wiper_a_pos, // tap selected on wiper a
  output logic [7:0] wiper_b_pos, // tap selected on wiper b
  output logic nv_ready // low while storage cycle runs
);

  localparam int CNT_W = $clog2(BUSY_CYCLES + 1);

  generate
    if (BUSY_CYCLES < 1) begin : g_bad_busy
      $error("BUSY_CYCLES must be at least one");
    end
  endgenerate

  // ----------------------------------------
  // shared decoding
  // ----------------------------------------
  function automatic frame_t frame_of(input logic [15:0] sh, input logic [4:0] n);
    frame_t f;
    f.cmd = (n == `FRAME_LONG) ? sh[15:8] : sh[7:0];
    f.data = sh[7:0];
    f.nbits = n;
    return f;
  endfunction

  function automatic logic cmd_ok(input frame_t f);
    return ((f.nbits == `FRAME_SHORT) || (f.nbits == `FRAME_LONG)) &&
           (f.cmd[`PAD_MSB:`PAD_LSB] == 2'h0) &&
           (f.cmd[`TGT_B_BIT:`TGT_A_BIT] != 2'h0);
  endfunction

  function automatic logic is_read(input frame_t f);
    return cmd_ok(f) && ((f.cmd[`OP_MSB:`OP_LSB] == `OP_RD_WIPER) ||
                         (f.cmd[`OP_MSB:`OP_LSB] == `OP_RD_NV));
  endfunction

  // ----------------------------------------
  // link side: shift-in
  // ----------------------------------------
  logic sel_mark_r;
  logic bit_mark_r;
  logic [15:0] shift_r;
  logic [4:0] cnt_r;

  // select fall makes the marks differ until the frame's first bit lands
  always_ff @(negedge chip_select_low or posedge sys_rst) begin
    if (sys_rst) begin
      sel_mark_r <= 1'b0;
    end else begin
      sel_mark_r <= ~bit_mark_r;
    end
  end

  // first edge of a frame restarts the count; saturation keeps long frames invalid
  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_r <= 16'h0000;
      cnt_r <= 5'h00;
      bit_mark_r <= 1'b0;
    end else if (!chip_select_low) begin
      shift_r <= {shift_r[14:0], sdio_in};
      bit_mark_r <= sel_mark_r;
      if (bit_mark_r != sel_mark_r) begin
        cnt_r <= 5'h01;
      end else if (cnt_r != `FRAME_SAT) begin
        cnt_r <= cnt_r + 5'h01;
      end
    end
  end

  // ----------------------------------------
  // link side: read-out
  // ----------------------------------------
  logic [7:0] rd_byte_r;
  logic rd_act_r;
  logic oe_r;
  logic sdo_r;
  logic [3:0] rd_idx_r;
  frame_t fr;

  assign fr = frame_of(shift_r, (bit_mark_r == sel_mark_r) ? cnt_r : 5'h00);

  // rd_byte_r is written by mclk a few cycles after select rises and is
  // stable long before the second serial edge, so it needs no crossing
  always_ff @(posedge sclk or posedge sys_rst or negedge chip_select_low) begin
    if (sys_rst) begin
      rd_act_r <= 1'b0;
      oe_r <= 1'b0;
      sdo_r <= 1'b0;
      rd_idx_r <= 4'h0;
    end else if (!chip_select_low) begin
      rd_act_r <= 1'b0;
      oe_r <= 1'b0;
      sdo_r <= 1'b0;
      rd_idx_r <= 4'hf; // marks the next select-high edge as the first
    end else if (rd_idx_r == 4'hf) begin
      rd_act_r <= is_read(fr);
      oe_r <= is_read(fr);
      rd_idx_r <= 4'h0;
    end else if (rd_act_r) begin
      if (rd_idx_r < 4'h8) begin
        sdo_r <= rd_byte_r[3'h7 - rd_idx_r[2:0]];
        rd_idx_r <= rd_idx_r + 4'h1;
      end else begin
        sdo_r <= 1'b0;
      end
    end
  end

  assign sdio_out = sdo_r;
  assign sdio_oe = oe_r & chip_select_low;

  // ----------------------------------------
  // crossings into mclk
  // ----------------------------------------
  logic cs_m1_r;
  logic cs_m2_r;
  logic cs_m3_r;
  logic mute_m1_r;
  logic mute_m2_r;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cs_m1_r <= 1'b1;
      cs_m2_r <= 1'b1;
      cs_m3_r <= 1'b1;
    end else begin
      cs_m1_r <= chip_select_low;
      cs_m2_r <= cs_m1_r;
      cs_m3_r <= cs_m2_r;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mute_m1_r <= 1'b0;
      mute_m2_r <= 1'b0;
    end else begin
      mute_m1_r <= mute;
      mute_m2_r <= mute_m1_r;
    end
  end

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  exec_state_t state_r;
  exec_state_t state_nxt;
  logic take;
  logic [3:0] op;
  logic [1:0] tgt;
  logic exec_ok;
  logic wr_wiper;
  logic cp_nv2w;
  logic wr_nv;
  logic cp_w2nv;
  logic rd_cmd;
  logic nv_start;

  // shift_r and cnt_r only move while select is low, so they are still here
  assign take = cs_m2_r & ~cs_m3_r;
  assign op = fr.cmd[`OP_MSB:`OP_LSB];
  assign tgt = fr.cmd[`TGT_B_BIT:`TGT_A_BIT];
  assign exec_ok = take && cmd_ok(fr) && (state_r != ST_LOAD);
  assign wr_wiper = exec_ok && (op == `OP_WR_WIPER) && (fr.nbits == `FRAME_LONG) &&
                    !mute_m2_r;
  assign cp_nv2w = exec_ok && (op == `OP_CP_NV2W) && !mute_m2_r;
  assign wr_nv = exec_ok && (op == `OP_WR_NV) && (fr.nbits == `FRAME_LONG) &&
                 (state_r == ST_IDLE);
  assign cp_w2nv = exec_ok && (op == `OP_CP_W2NV) && (state_r == ST_IDLE);
  assign rd_cmd = exec_ok && ((op == `OP_RD_WIPER) || (op == `OP_RD_NV));
  assign nv_start = wr_nv | cp_w2nv;

  // ----------------------------------------
  // sequencing and storage timer
  // ----------------------------------------
  logic [CNT_W-1:0] busy_cnt_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_LOAD: state_nxt = ST_IDLE;
      ST_IDLE: begin
        if (nv_start) begin
          state_nxt = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (busy_cnt_r == CNT_W'(BUSY_CYCLES - 1)) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_LOAD;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_cnt_r <= '0;
    end else if (state_r == ST_BUSY) begin
      busy_cnt_r <= busy_cnt_r + CNT_W'(1);
    end else begin
      busy_cnt_r <= '0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      nv_ready <= 1'b1;
    end else begin
      nv_ready <= (state_nxt != ST_BUSY);
    end
  end

  // ----------------------------------------
  // wiper and nonvolatile stores
  // ----------------------------------------
  logic [7:0] wiper_r [2];
  logic [7:0] nv_r [2];
  logic [7:0] pos_r [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          wiper_r[g] <= `WIPER_RESET;
        end else if (state_r == ST_LOAD) begin
          wiper_r[g] <= nv_r[g];
        end else if (wr_wiper && tgt[g]) begin
          wiper_r[g] <= fr.data;
        end else if (cp_nv2w && tgt[g]) begin
          wiper_r[g] <= nv_r[g];
        end
      end

      // mute has no path in here, so stored copies survive it
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          nv_r[g] <= `NV_RESET;
        end else if (wr_nv && tgt[g]) begin
          nv_r[g] <= fr.data;
        end else if (cp_w2nv && tgt[g]) begin
          nv_r[g] <= wiper_r[g];
        end
      end

      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          pos_r[g] <= `WIPER_RESET;
        end else begin
          pos_r[g] <= mute_m2_r ? 8'h00 : wiper_r[g];
        end
      end
    end
  endgenerate

  assign wiper_a_pos = pos_r[0];
  assign wiper_b_pos = pos_r[1];

  // target 11 on a read returns channel a
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_byte_r <= 8'h00;
    end else if (rd_cmd) begin
      if (op == `OP_RD_NV) begin
        rd_byte_r <= tgt[`TGT_A_BIT] ? nv_r[0] : nv_r[1];
      end else begin
        rd_byte_r <= tgt[`TGT_A_BIT] ? wiper_r[0] : wiper_r[1];
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  mute_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
    mute_m2_r |=> (wiper_a_pos == 8'h00) && (wiper_b_pos == 8'h00))
    else $error("wiper not zero under mute");

  mute_release_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !mute_m2_r |=> (wiper_a_pos == $past(wiper_r[0])) && (wiper_b_pos == $past(wiper_r[1])))
    else $error("wiper not restored after mute");

  busy_ready_a: assert property (@(posedge mclk) disable iff (sys_rst)
    nv_start |=> !nv_ready throughout (state_r == ST_BUSY)[*2])
    else $error("ready not low during storage");

  busy_end_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(nv_ready) |-> $past(busy_cnt_r) == CNT_W'(BUSY_CYCLES - 1))
    else $error("storage time wrong");

  nv_keep_wiper_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_nv |=> $stable(wiper_r[0]) && $stable(wiper_r[1]))
    else $error("nonvolatile write moved a wiper");

  wiper_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (wr_wiper && tgt[0]) |=> wiper_r[0] == $past(fr.data))
    else $error("wiper a not written");

  mute_drop_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (take && mute_m2_r && (state_r != ST_LOAD)) |=> $stable(wiper_r[0]) && $stable(wiper_r[1]))
    else $error("wiper changed under mute");

  bad_len_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (take && (fr.nbits != `FRAME_SHORT) && (fr.nbits != `FRAME_LONG) && (state_r != ST_LOAD))
    |=> $stable(wiper_r[0]) && $stable(nv_r[0]) && $stable(nv_r[1]))
    else $error("bad length frame executed");

  copy_store_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (cp_w2nv && tgt[1]) |=> nv_r[1] == $past(wiper_r[1]))
    else $error("copy to store failed");

  read_start_a: assert property (@(posedge sclk) disable iff (sys_rst)
    (chip_select_low && (rd_idx_r == 4'hf) && is_read(fr)) |=> oe_r ##1 (rd_idx_r == 4'h1))
    else $error("read-out did not start on time");

endmodule
`default_nettype wire

// ### tb/pot_host.sv
`timescale 1ns/1ns
`default_nettype none
module pot_host (
  output logic sclk, // link clock, runs inside frames and during read-out after select rises
  output logic chip_select_low, // frame select
  output logic sdio_line, // resolved data pin level
  input wire logic dev_out, // level the device drives
  input wire logic dev_oe // device drive enable
);
  logic host_bit;
  logic host_oe;
  logic float_r;
  logic clash;
  initial begin
    sclk = 1'b0;
    chip_select_low = 1'b1;
    host_bit = 1'b0;
    host_oe = 1'b0;
    float_r = 1'b0;
    clash = 1'b0;
  end
  // nobody drives: pin wanders so a stale bit never passes for data
  always #37 float_r = ~float_r;
  assign sdio_line = host_oe ? host_bit : (dev_oe ? dev_out : float_r);

  task automatic frame(input logic [15:0] word, input int n);
    chip_select_low = 1'b0;
    host_oe = 1'b1;
    for (int i = 0; i < n; i++) begin
      host_bit = (i < 16) ? word[15 - i] : 1'b0;
      #80 sclk = 1'b1;
      if (dev_oe) clash = 1'b1;
      #80 sclk = 1'b0;
    end
    #40 host_oe = 1'b0;
    chip_select_low = 1'b1;
    #300;
  endtask

  // select pulse with no clock in it: carries zero bits
  task automatic pulse;
    chip_select_low = 1'b0;
    #100 chip_select_low = 1'b1;
    #300;
  endtask

  task automatic readout(output logic [7:0] val, output logic oe1, output logic oe2);
    #80;
    for (int i = 0; i < 9; i++) begin
      sclk = 1'b1;
      #40;
      if (i == 0) oe1 = dev_oe;
      else val[8 - i] = sdio_line;
      #40 sclk = 1'b0;
      #80;
    end
    chip_select_low = 1'b0;
    #20 oe2 = dev_oe;
    #80 chip_select_low = 1'b1;
    #300;
  endtask
endmodule
`default_nettype wire

// ### tb/dual_wiper_serial_command_unit_tb.sv
`timescale 1ns/1ns
`default_nettype none
module dual_wiper_serial_command_unit_tb;
  localparam int BUSY = 50;
  logic mclk;
  logic sys_rst;
  logic mute;
  logic sclk;
  logic chip_select_low;
  logic sdio_in;
  logic sdio_out;
  logic sdio_oe;
  logic [7:0] wa;
  logic [7:0] wb;
  logic nv_ready;
  int n_errors;
  int checks;

  dual_wiper_serial_command_unit #(.BUSY_CYCLES(BUSY)) i_dut (
    .mclk(mclk), .sys_rst(sys_rst), .sclk(sclk), .chip_select_low(chip_select_low),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .mute(mute),
    .wiper_a_pos(wa), .wiper_b_pos(wb), .nv_ready(nv_ready)
  );
  pot_host i_host (
    .sclk(sclk), .chip_select_low(chip_select_low), .sdio_line(sdio_in),
    .dev_out(sdio_out), .dev_oe(sdio_oe)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] word, input int n);
    @(posedge mclk);
    #1 i_host.frame(word, n);
  endtask

  task automatic rd(input logic [15:0] word, input int n, input logic [7:0] exp);
    logic [7:0] v;
    logic oe1;
    logic oe2;
    wr(word, n);
    i_host.readout(v, oe1, oe2);
    chk({7'h00, oe1}, 8'h01);
    chk(v, exp);
    chk({7'h00, oe2}, 8'h00);
  endtask

  // store commands: count mclk cycles with ready low
  task automatic store(input logic [15:0] word, input int n);
    int lows;
    lows = 0;
    @(posedge mclk);
    #1;
    fork
      i_host.frame(word, n);
      repeat (400) begin
        @(negedge mclk);
        if (nv_ready === 1'b0) lows++;
      end
    join
    chk(lows[7:0], BUSY[7:0]);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_powerup;
    repeat (8) @(posedge mclk);
    #1 chk(wa, 8'h80);
    chk(wb, 8'h80);
    chk({7'h00, nv_ready}, 8'h01);
  endtask

  task automatic t_wiper;
    wr(16'h03ff, 16);
    chk(wa, 8'hff);
    chk(wb, 8'hff);
    wr(16'h0300, 16);
    chk(wa, 8'h00);
    wr(16'h015a, 16);
    wr(16'h02a5, 16);
    chk(wa, 8'h5a);
    chk(wb, 8'ha5);
  endtask

  task automatic t_nv;
    rd(16'h5100, 8, 8'h80);
    store(16'h1133, 16);
    chk(wa, 8'h5a);
    rd(16'h5100, 8, 8'h33);
    store(16'h1377, 16);
    rd(16'h52c3, 16, 8'h77);
    rd(16'h5100, 8, 8'h77);
    rd(16'h4200, 8, 8'ha5);
    chk(wb, 8'ha5);
  endtask

  task automatic t_copy;
    store(16'h2100, 8);
    @(posedge mclk);
    #1 i_host.pulse();
    chk({7'h00, nv_ready}, 8'h01);
    rd(16'h5100, 8, 8'h5a);
    rd(16'h5300, 16, 8'h5a);
    wr(16'h0100, 16);
    wr(16'h3100, 16);
    chk(wa, 8'h5a);
    wr(16'h3300, 8);
    chk(wb, 8'h77);
  endtask

  task automatic t_badlen;
    wr(16'h0111, 12);
    wr(16'h0380, 9);
    wr(16'h0322, 17);
    wr(16'h0d11, 16);
    wr(16'h0100, 8);
    wr(16'h0033, 16);
    chk(wa, 8'h5a);
    chk(wb, 8'h77);
  endtask

  task automatic t_mute;
    @(posedge mclk);
    #1 mute = 1'b1;
    repeat (8) @(posedge mclk);
    #1 chk(wa, 8'h00);
    chk(wb, 8'h00);
    wr(16'h0144, 16);
    chk(wa, 8'h00);
    rd(16'h5100, 8, 8'h5a);
    @(posedge mclk);
    #1 mute = 1'b0;
    repeat (8) @(posedge mclk);
    #1 chk(wa, 8'h5a);
    chk(wb, 8'h77);
  endtask

  task automatic report_and_stop;
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #500000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    n_errors = 0;
    checks = 0;
    sys_rst = 1'b1;
    mute = 1'b0;
    repeat (4) @(posedge mclk);
    #1 sys_rst = 1'b0;
    t_powerup();
    t_wiper();
    t_nv();
    t_copy();
    t_badlen();
    t_mute();
    chk({7'h00, i_host.clash}, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
